// ### tb_video_control_register_bank.sv
// Self-checking bench for the video control register bank.
`timescale 1ns/1ns
`default_nettype none
module tb_video_control_register_bank;
  typedef struct {
    logic [7:0] sub;
    logic [15:0] wr;
    int n;
    logic [15:0] exp;
  } vcr_row_t;
  vcr_row_t rows [7] = '{'{8'h1F, 16'hFFFF, 2, 16'h0FD8},
    '{8'h20, 16'h00FF, 1, 16'h00BF}, '{8'h1F, 16'h0A48, 2, 16'h0A48},
    '{8'h20, 16'h0094, 1, 16'h0094}, '{8'h36, 16'h0123, 2, 16'h0000},
    '{8'h1F, 16'h0590, 2, 16'h0590}, '{8'h20, 16'h0028, 1, 16'h0028}};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic scl, sda, sda_oe_n, blk_restart, av_out, luma_oe_n, chroma_oe_n, ok;
  logic blk_update = 1'b0;
  logic av_in = 1'b0;
  logic [3:0] sy_in = 4'h0;
  logic [2:0] ck_in = 3'h0;
  logic [4:0] fifo_in = 5'h00;
  logic [7:0] luma_in = 8'h00;
  logic [7:0] chroma_in = 8'h00;
  logic [3:0] sy_out;
  logic [5:0] oe_n;
  logic [2:0] ck_out;
  logic [4:0] fifo_out;
  logic [7:0] luma_out, chroma_out;
  logic [15:0] rd, pin, sync;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  int restarts = 0;
  int na, nl;

  vcr_host host_u (.clk(clk), .sda_oe_n(sda_oe_n), .scl(scl), .sda(sda));

  vcr_bank dut_u (.clk(clk), .rst(rst), .scl_i(scl), .sda_i(sda),
    .sda_o(), .sda_oe_n(sda_oe_n), .blk_update(blk_update),
    .blk_bottom_in(7'h15), .blk_top_in(7'h2A), .blk_pic_in(1'b1),
    .blk_restart(blk_restart), .av_in(av_in), .hs_in(sy_in[0]),
    .hc_in(sy_in[1]), .vs_in(sy_in[2]), .field_in(sy_in[3]),
    .luma_in(luma_in), .chroma_in(chroma_in), .line_locked_clock_one_in(ck_in[0]),
    .line_locked_clock_two_in(ck_in[1]), .fixed_twenty_mhz_clock_in(ck_in[2]), .fifo_ctl_in(fifo_in),
    .active_video_output(av_out), .active_video_oe_n(oe_n[5]),
    .horizontal_sync_output(sy_out[0]), .horizontal_clamp_output(sy_out[1]),
    .vertical_sync_output(sy_out[2]), .interlace_field_output(sy_out[3]),
    .sync_pins_oe_n(oe_n[4]), .line_locked_clock_one(ck_out[0]),
    .line_clock_one_oe_n(oe_n[3]), .line_locked_clock_two(ck_out[1]),
    .line_clock_two_oe_n(oe_n[2]), .fixed_twenty_mhz_clock(ck_out[2]),
    .fixed_clock_oe_n(oe_n[1]), .fifo_ctl_out(fifo_out),
    .fifo_ctl_oe_n(oe_n[0]), .luma_data_out(luma_out), .luma_oe_n(luma_oe_n),
    .chroma_data_out(chroma_out), .chroma_oe_n(chroma_oe_n));

  initial
  begin
    forever #4 clk = ~clk;
  end

  task automatic test_done();
    if (failures == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic reset_check();
    host_u.read_reg(8'h1F, 2, rd, ok);
    check("pins", 16'h0000, rd);
    host_u.read_reg(8'h20, 1, rd, ok);
    check("sync", 16'h0000, rd);
    check("oe", 8'h03, {oe_n, chroma_oe_n, luma_oe_n});
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (blk_restart === 1'b1)
      restarts++;
    if (cycles == 60000)
    begin
      failures++;
      test_done();
    end
  end

  initial
  begin
    repeat (12) @(posedge clk);
    #1;
    rst = 1'b0;
    reset_check();
    pin = 16'h0000;
    sync = 16'h0000;
    foreach (rows[r])
    begin
      sy_in = 4'(r * 5 + 3);
      ck_in = 3'(r * 3 + 2);
      fifo_in = 5'(r * 7 + 9);
      chroma_in = 8'(r * 61 + 1);
      host_u.write_reg(rows[r].sub, rows[r].wr, rows[r].n, ok);
      check("ack", 1, ok);
      host_u.read_reg(rows[r].sub, rows[r].n, rd, ok);
      check("readback", rows[r].exp, rd);
      if (rows[r].sub == 8'h1F)
        pin = rows[r].exp;
      if (rows[r].sub == 8'h20)
        sync = rows[r].exp;
      check("oe", {pin[3], pin[4], pin[6], pin[7], pin[8], pin[9], ~pin[10],
        ~pin[11]},
        {oe_n, chroma_oe_n, luma_oe_n});
      check("polarity", {sy_in ^ {sync[7], sync[5], sync[3], sync[2]},
        sync[4]}, {sy_out, av_out});
      check("pass", {ck_in, fifo_in, chroma_in},
        {ck_out, fifo_out, chroma_out});
    end
    for (int l = 0; l < 4; l++)
    begin
      host_u.write_reg(8'h20, 16'(l), 1, ok);
      repeat (8) @(posedge clk);
      #1;
      av_in = 1'b1;
      luma_in = 8'hC3;
      na = 0;
      nl = 0;
      for (int c = 1; c < 12; c++)
      begin
        @(posedge clk);
        #1;
        if (na == 0 && av_out === 1'b1)
          na = c;
        if (nl == 0 && luma_out === 8'hC3)
          nl = c;
      end
      check("lead", l, nl - na);
      av_in = 1'b0;
      luma_in = 8'h00;
    end
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    reset_check();
    host_u.write_reg(8'h38, 16'h00AB, 1, ok);
    host_u.read_reg(8'h35, 1, rd, ok);
    check("pending", 16'h0001, rd);
    host_u.write_reg(8'h37, 16'h01FE, 2, ok);
    host_u.write_reg(8'h38, 16'hA55A, 3, ok);
    host_u.write_reg(8'h38, 16'h1234, 2, ok);
    check("ack", 1, ok);
    host_u.read_reg(8'h35, 1, rd, ok);
    check("idle", 16'h0000, rd);
    host_u.write_reg(8'h36, 16'h01FE, 2, ok);
    host_u.read_reg(8'h38, 2, rd, ok);
    check("word0", 16'hA55A, rd);
    host_u.read_reg(8'h38, 2, rd, ok);
    check("word1", 16'h1234, rd);
    @(posedge clk);
    #1;
    blk_update = 1'b1;
    @(posedge clk);
    #1;
    blk_update = 1'b0;
    restarts = 0;
    host_u.read_reg(8'h12, 2, rd, ok);
    check("black", 16'hAA15, rd);
    check("restart", 1, restarts);
    host_u.read_reg(8'h12, 2, rd, ok);
    check("fresh", 16'h7F7F, rd & 16'h7FFF);
    host_u.start();
    host_u.byte_out(8'h20, ok);
    host_u.stop();
    check("foreign", 0, ok);
    test_done();
  end
endmodule
`default_nettype wire

// ### vcr_bank.sv
// Serial-port register bank: indirect memory, black lines, pins and sync.
`timescale 1ns/1ns
`default_nettype none
module vcr_bank
(
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  input wire logic blk_update,
  input wire logic [6:0] blk_bottom_in,
  input wire logic [6:0] blk_top_in,
  input wire logic blk_pic_in,
  output logic blk_restart,
  input wire logic av_in,
  input wire logic hs_in,
  input wire logic hc_in,
  input wire logic vs_in,
  input wire logic field_in,
  input wire logic [7:0] luma_in,
  input wire logic [7:0] chroma_in,
  input wire logic line_locked_clock_one_in,
  input wire logic line_locked_clock_two_in,
  input wire logic fixed_twenty_mhz_clock_in,
  input wire logic [4:0] fifo_ctl_in,
  output logic active_video_output,
  output logic active_video_oe_n,
  output logic horizontal_sync_output,
  output logic horizontal_clamp_output,
  output logic vertical_sync_output,
  output logic interlace_field_output,
  output logic sync_pins_oe_n,
  output logic line_locked_clock_one,
  output logic line_clock_one_oe_n,
  output logic line_locked_clock_two,
  output logic line_clock_two_oe_n,
  output logic fixed_twenty_mhz_clock,
  output logic fixed_clock_oe_n,
  output logic [4:0] fifo_ctl_out,
  output logic fifo_ctl_oe_n,
  output logic [7:0] luma_data_out,
  output logic luma_oe_n,
  output logic [7:0] chroma_data_out,
  output logic chroma_oe_n
);

  typedef struct packed {
    logic [2:0] scl_sy;
    logic [2:0] sda_sy;
    vcr_pkg::vcr_ser_st_t st;
    logic [3:0] cnt;
    logic [7:0] shift;
    logic ack;
    logic sda_drv;
    logic [7:0] sub;
    logic [1:0] byte_idx;
    logic [7:0] hi;
    logic [15:0] tx_word;
    logic [8:0] rd_addr;
    logic [8:0] wr_addr;
    logic [8:0] mem_waddr;
    logic mem_we;
    logic [15:0] mem_wdata;
    logic wr_req;
    logic rd_req;
    logic [6:0] bottom;
    logic [6:0] top;
    logic blk_pic;
    logic blk_restart;
    logic [15:0] pin_ctl;
    logic [7:0] sync_ctl;
    logic [3:0] av_dly;
    logic [3:0][7:0] y_dly;
    logic [3:0][7:0] c_dly;
    logic av_o;
    logic hs_o;
    logic hc_o;
    logic vs_o;
    logic fld_o;
    logic [7:0] y_o;
    logic [7:0] c_o;
    logic line_locked_clock_one_o;
    logic line_locked_clock_two_o;
    logic fixed_twenty_mhz_clock_o;
    logic [4:0] fifo_o;
  } vcr_bank_state_t;

  vcr_bank_state_t q;
  vcr_bank_state_t d;
  logic [15:0] mem_rdata;
  logic scl_rise;
  logic scl_fall;
  logic ser_start;
  logic ser_stop;
  logic [7:0] rx_byte;
  logic byte_done;
  logic wide;
  logic wr_commit;
  logic [15:0] commit_word;
  logic tx_load;
  logic rd_done;
  logic [1:0] lead;

  vcr_word_ram u_ram
  (
    .clk(clk),
    .rst(rst),
    .we(q.mem_we),
    .waddr(q.mem_waddr),
    .wdata(q.mem_wdata),
    .raddr(q.rd_addr),
    .rdata(mem_rdata)
  );

  // Read view of every register; unmapped and write-only ones read zero.
  function automatic logic [15:0] rd_value(input logic [7:0] sub);
    logic [15:0] v;
    v = 16'h0000;
    unique case (sub)
      vcr_pkg::SUB_BLACK_LINE: v = {q.blk_pic, q.top, 1'b0, q.bottom};
      vcr_pkg::SUB_PIN_DRIVE: v = q.pin_ctl & vcr_pkg::PIN_MASK;
      vcr_pkg::SUB_SYNC_OUT: v = {8'h00, q.sync_ctl};
      vcr_pkg::SUB_IND_STATUS: v = {13'h0, q.mem_we, q.rd_req, q.wr_req};
      vcr_pkg::SUB_IND_DATA: v = mem_rdata;
      default: v = 16'h0000;
    endcase
    return v;
  endfunction

  assign scl_rise = q.scl_sy[1] & ~q.scl_sy[2];
  assign scl_fall = ~q.scl_sy[1] & q.scl_sy[2];
  assign ser_start = q.scl_sy[1] & q.scl_sy[2] & q.sda_sy[2] & ~q.sda_sy[1];
  assign ser_stop = q.scl_sy[1] & q.scl_sy[2] & ~q.sda_sy[2] & q.sda_sy[1];
  assign rx_byte = {q.shift[6:0], q.sda_sy[1]};
  assign byte_done = scl_rise && q.cnt == vcr_pkg::BYTE_LAST_BIT &&
    q.st != vcr_pkg::st_idle && q.st != vcr_pkg::st_rd;
  assign wide = q.sub != vcr_pkg::SUB_SYNC_OUT &&
    q.sub != vcr_pkg::SUB_IND_STATUS;
  assign wr_commit = byte_done && q.st == vcr_pkg::st_wr &&
    ((q.byte_idx == 2'h0 && !wide) || (q.byte_idx == 2'h1 && wide));
  assign commit_word = wide ? {q.hi, rx_byte} : {8'h00, rx_byte};
  assign tx_load = scl_fall && q.cnt == vcr_pkg::ACK_DONE_CNT &&
    q.st == vcr_pkg::st_rd;
  assign rd_done = tx_load &&
    ((wide && q.byte_idx == 2'h1) || (!wide && q.byte_idx == 2'h0));
  assign lead = q.sync_ctl[vcr_pkg::SYNC_LEAD_LSB +: 2];

  always_comb
  begin
    logic [7:0] tx_byte;
    tx_byte = 8'h00;
    d = q;
    d.scl_sy = {q.scl_sy[1:0], scl_i};
    d.sda_sy = {q.sda_sy[1:0], sda_i};
    d.mem_we = 1'b0;
    d.blk_restart = 1'b0;
    // A written word has reached memory, so the request is complete.
    if (q.mem_we)
      d.wr_req = 1'b0;
    if (blk_update)
    begin
      d.bottom = blk_bottom_in;
      d.top = blk_top_in;
      d.blk_pic = blk_pic_in;
    end
    if (ser_start)
    begin
      d.st = vcr_pkg::st_addr;
      d.cnt = 4'h0;
      d.sda_drv = 1'b0;
    end
    else if (ser_stop)
    begin
      d.st = vcr_pkg::st_idle;
      d.sda_drv = 1'b0;
    end
    else if (q.st != vcr_pkg::st_idle)
    begin
      if (scl_rise)
      begin
        if (q.cnt == vcr_pkg::ACK_DRIVE_CNT)
        begin
          d.cnt = vcr_pkg::ACK_DONE_CNT;
          // A refused byte from the host ends the read burst.
          if (q.st == vcr_pkg::st_rd && q.sda_sy[1])
            d.st = vcr_pkg::st_idle;
        end
        else
        begin
          d.cnt = q.cnt + 4'h1;
          if (q.st != vcr_pkg::st_rd)
            d.shift = rx_byte;
        end
      end
      if (byte_done)
      begin
        d.ack = 1'b1;
        unique case (q.st)
          vcr_pkg::st_addr:
          begin
            d.byte_idx = 2'h0;
            if (rx_byte[7:1] != vcr_pkg::DEV_ADDR)
            begin
              d.ack = 1'b0;
              d.st = vcr_pkg::st_idle;
            end
            else if (rx_byte[0])
            begin
              d.st = vcr_pkg::st_rd;
              d.tx_word = rd_value(q.sub);
              if (q.sub == vcr_pkg::SUB_IND_DATA)
                d.rd_req = 1'b1;
            end
            else
              d.st = vcr_pkg::st_sub;
          end
          vcr_pkg::st_sub:
          begin
            d.sub = rx_byte;
            d.byte_idx = 2'h0;
            d.st = vcr_pkg::st_wr;
          end
          default:
          begin
            if (q.byte_idx != 2'h2)
              d.byte_idx = q.byte_idx + 2'h1;
            if (q.byte_idx == 2'h0)
            begin
              d.hi = rx_byte;
              if (q.sub == vcr_pkg::SUB_IND_DATA)
                d.wr_req = 1'b1;
            end
          end
        endcase
      end
      if (wr_commit)
      begin
        unique case (q.sub)
          vcr_pkg::SUB_IND_RD_ADDR: d.rd_addr = commit_word[8:0];
          vcr_pkg::SUB_IND_WR_ADDR: d.wr_addr = commit_word[8:0];
          vcr_pkg::SUB_IND_DATA:
          begin
            d.mem_we = 1'b1;
            d.mem_wdata = commit_word;
            d.mem_waddr = q.wr_addr;
            d.wr_addr = q.wr_addr + vcr_pkg::ADDR_STEP;
          end
          vcr_pkg::SUB_PIN_DRIVE: d.pin_ctl = commit_word & vcr_pkg::PIN_MASK;
          vcr_pkg::SUB_SYNC_OUT:
            d.sync_ctl = commit_word[7:0] & vcr_pkg::SYNC_MASK;
          default: d.hi = q.hi;
        endcase
      end
      if (scl_fall)
      begin
        if (q.cnt == vcr_pkg::ACK_DRIVE_CNT)
          d.sda_drv = q.ack && q.st != vcr_pkg::st_idle;
        else if (q.cnt == vcr_pkg::ACK_DONE_CNT)
        begin
          d.cnt = 4'h0;
          d.sda_drv = 1'b0;
          d.ack = 1'b0;
        end
        else if (q.st == vcr_pkg::st_rd && q.cnt != 4'h0)
        begin
          d.sda_drv = ~q.shift[7];
          d.shift = {q.shift[6:0], 1'b0};
        end
      end
      if (tx_load)
      begin
        if (q.byte_idx == 2'h0)
          tx_byte = wide ? q.tx_word[15:8] : q.tx_word[7:0];
        else if (q.byte_idx == 2'h1 && wide)
          tx_byte = q.tx_word[7:0];
        d.shift = {tx_byte[6:0], 1'b0};
        d.sda_drv = ~tx_byte[7];
        if (q.byte_idx != 2'h2)
          d.byte_idx = q.byte_idx + 2'h1;
      end
      if (rd_done)
      begin
        if (q.sub == vcr_pkg::SUB_IND_DATA)
        begin
          d.rd_addr = q.rd_addr + vcr_pkg::ADDR_STEP;
          d.rd_req = 1'b0;
        end
        if (q.sub == vcr_pkg::SUB_BLACK_LINE)
        begin
          d.bottom = vcr_pkg::BLK_RESTART_COUNT;
          d.top = vcr_pkg::BLK_RESTART_COUNT;
          d.blk_restart = 1'b1;
        end
      end
    end
    // Pixel data is held for the longest lead, and active video taps early.
    d.av_dly = {q.av_dly[2:0], av_in};
    d.y_dly = {q.y_dly[2:0], luma_in};
    d.c_dly = {q.c_dly[2:0], chroma_in};
    d.av_o = q.av_dly[vcr_pkg::LEAD_MAX - lead] ^
      q.sync_ctl[vcr_pkg::SYNC_AVO_INV];
    d.y_o = q.y_dly[3];
    d.c_o = q.c_dly[3];
    d.hs_o = hs_in ^ q.sync_ctl[vcr_pkg::SYNC_HS_INV];
    d.hc_o = hc_in ^ q.sync_ctl[vcr_pkg::SYNC_HC_INV];
    d.vs_o = vs_in ^ q.sync_ctl[vcr_pkg::SYNC_VS_INV];
    d.fld_o = field_in ^ q.sync_ctl[vcr_pkg::SYNC_FIELD_INV];
    d.line_locked_clock_one_o = line_locked_clock_one_in;
    d.line_locked_clock_two_o = line_locked_clock_two_in;
    d.fixed_twenty_mhz_clock_o = fixed_twenty_mhz_clock_in;
    d.fifo_o = fifo_ctl_in;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      q <= '0;
    else
      q <= d;
  end

  assign sda_o = 1'b0;
  assign sda_oe_n = ~q.sda_drv;
  assign blk_restart = q.blk_restart;
  assign active_video_output = q.av_o;
  assign horizontal_sync_output = q.hs_o;
  assign horizontal_clamp_output = q.hc_o;
  assign vertical_sync_output = q.vs_o;
  assign interlace_field_output = q.fld_o;
  assign line_locked_clock_one = q.line_locked_clock_one_o;
  assign line_locked_clock_two = q.line_locked_clock_two_o;
  assign fixed_twenty_mhz_clock = q.fixed_twenty_mhz_clock_o;
  assign fifo_ctl_out = q.fifo_o;
  assign luma_data_out = q.y_o;
  assign chroma_data_out = q.c_o;
  assign active_video_oe_n = q.pin_ctl[vcr_pkg::PIN_AVO_BIT];
  assign sync_pins_oe_n = q.pin_ctl[vcr_pkg::PIN_SYNC_BIT];
  assign line_clock_one_oe_n = q.pin_ctl[vcr_pkg::PIN_LINE_LOCKED_CLOCK_ONE_BIT];
  assign line_clock_two_oe_n = q.pin_ctl[vcr_pkg::PIN_LINE_LOCKED_CLOCK_TWO_BIT];
  assign fixed_clock_oe_n = q.pin_ctl[vcr_pkg::PIN_FIXED_TWENTY_MHZ_CLOCK_BIT];
  assign fifo_ctl_oe_n = q.pin_ctl[vcr_pkg::PIN_FIFO_BIT];
  assign chroma_oe_n = ~q.pin_ctl[vcr_pkg::PIN_CHROMA_BIT];
  assign luma_oe_n = ~q.pin_ctl[vcr_pkg::PIN_LUMA_BIT];

  sequence s_data_word;
    wr_commit && q.sub == vcr_pkg::SUB_IND_DATA;
  endsequence

  property p_rd_addr_load;
    @(posedge clk) disable iff (rst)
    (wr_commit && q.sub == vcr_pkg::SUB_IND_RD_ADDR) |=>
      q.rd_addr == $past(commit_word[8:0]);
  endproperty
  a_rd_addr_load: assert property (p_rd_addr_load)
    else $error("read address not loaded");

  property p_wr_step;
    @(posedge clk) disable iff (rst)
    s_data_word |=> q.mem_we && q.mem_wdata == $past(commit_word) &&
      q.wr_addr == q.mem_waddr + vcr_pkg::ADDR_STEP;
  endproperty
  a_wr_step: assert property (p_wr_step)
    else $error("data word not written or address not stepped");

  property p_one_word;
    @(posedge clk) disable iff (rst)
    (byte_done && q.st == vcr_pkg::st_wr && q.byte_idx == 2'h2) |=>
      !q.mem_we;
  endproperty
  a_one_word: assert property (p_one_word)
    else $error("extra byte reached memory");

  property p_blk_restart;
    @(posedge clk) disable iff (rst)
    (rd_done && q.sub == vcr_pkg::SUB_BLACK_LINE) |=>
      q.blk_restart && q.bottom == vcr_pkg::BLK_RESTART_COUNT &&
      q.top == vcr_pkg::BLK_RESTART_COUNT ##1 !q.blk_restart;
  endproperty
  a_blk_restart: assert property (p_blk_restart)
    else $error("black-line counts not restarted");

  // The word handed to the shifter must carry the counts as they stood.
  property p_blk_word;
    @(posedge clk) disable iff (rst)
    (byte_done && q.st == vcr_pkg::st_addr && rx_byte[0] &&
      rx_byte[7:1] == vcr_pkg::DEV_ADDR &&
      q.sub == vcr_pkg::SUB_BLACK_LINE) |=>
      q.tx_word[7] == 1'b0 && q.tx_word[14:8] == $past(q.top) &&
      q.tx_word[6:0] == $past(q.bottom) &&
      q.tx_word[15] == $past(q.blk_pic);
  endproperty
  a_blk_word: assert property (p_blk_word)
    else $error("black-line word layout wrong");

  property p_avo_float;
    @(posedge clk) disable iff (rst)
    (wr_commit && q.sub == vcr_pkg::SUB_PIN_DRIVE) |=>
      active_video_oe_n == $past(commit_word[vcr_pkg::PIN_AVO_BIT]) &&
      luma_oe_n == !$past(commit_word[vcr_pkg::PIN_LUMA_BIT]);
  endproperty
  a_avo_float: assert property (p_avo_float)
    else $error("pin drive not taken from written word");

  property p_lead;
    @(posedge clk) disable iff (rst)
    ($past(lead) == 2'h3 && !$past(rst, 2)) |->
      active_video_output ==
      ($past(av_in, 2) ^ $past(q.sync_ctl[vcr_pkg::SYNC_AVO_INV]));
  endproperty
  a_lead: assert property (p_lead)
    else $error("active video lead of three wrong");

  // A reset anywhere in the last five cycles flushes the pixel pipe.
  property p_pixel_delay;
    @(posedge clk) disable iff (rst)
    (!$past(rst) && !$past(rst, 2) && !$past(rst, 3) && !$past(rst, 4) &&
      !$past(rst, 5)) |-> luma_data_out == $past(luma_in, 5);
  endproperty
  a_pixel_delay: assert property (p_pixel_delay)
    else $error("pixel data delay wrong");

  property p_hs_pol;
    @(posedge clk) disable iff (rst)
    !$past(rst) |-> horizontal_sync_output ==
      ($past(hs_in) ^ $past(q.sync_ctl[vcr_pkg::SYNC_HS_INV]));
  endproperty
  a_hs_pol: assert property (p_hs_pol)
    else $error("horizontal sync polarity wrong");

  property p_upper_zero;
    @(posedge clk) disable iff (rst)
    (q.pin_ctl & ~vcr_pkg::PIN_MASK) == 16'h0000 &&
      (q.sync_ctl & ~vcr_pkg::SYNC_MASK) == 8'h00;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("unused bits read nonzero");

endmodule
`default_nettype wire

// ### vcr_host.sv
// Serial control host model that drives the bank's clock and data pins.
`timescale 1ns/1ns
`default_nettype none
module vcr_host
(
  input wire logic clk,
  input wire logic sda_oe_n,
  output logic scl,
  output logic sda
);
  logic scl_q = 1'b1;
  logic sda_q = 1'b1;

  // The pull-up wins wherever neither side pulls the data line low.
  assign sda = sda_q & sda_oe_n;
  assign scl = scl_q;

  // Four clocks per phase keeps every level well above the minimum the port needs.
  task automatic tick();
    repeat (4) @(posedge clk);
    #1;
  endtask

  task automatic start();
    sda_q = 1'b1;
    tick();
    scl_q = 1'b1;
    tick();
    sda_q = 1'b0;
    tick();
    scl_q = 1'b0;
    tick();
  endtask

  task automatic stop();
    sda_q = 1'b0;
    tick();
    scl_q = 1'b1;
    tick();
    sda_q = 1'b1;
    tick();
  endtask

  task automatic bit_io(input logic b, output logic r);
    sda_q = b;
    tick();
    scl_q = 1'b1;
    tick();
    r = sda;
    scl_q = 1'b0;
    tick();
  endtask

  task automatic byte_out(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask

  task automatic byte_in(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, b[i]);
    bit_io(last, r);
  endtask

  task automatic write_reg(input logic [7:0] sub, input logic [15:0] d,
    input int n, output logic ok);
    logic a;
    ok = 1'b0;
    if (sub == vcr_pkg::SUB_BLACK_LINE)
      return;
    start();
    byte_out({vcr_pkg::DEV_ADDR, 1'b0}, ok);
    byte_out(sub, a);
    ok &= a;
    for (int i = 0; i < n; i++)
    begin
      byte_out((i == 0 && n > 1) ? d[15:8] : (i < 2 ? d[7:0] : 8'hFF), a);
      ok &= a;
    end
    stop();
  endtask

  task automatic read_reg(input logic [7:0] sub, input int n,
    output logic [15:0] d, output logic ok);
    logic a;
    logic [7:0] b;
    start();
    byte_out({vcr_pkg::DEV_ADDR, 1'b0}, ok);
    byte_out(sub, a);
    ok &= a;
    start();
    byte_out({vcr_pkg::DEV_ADDR, 1'b1}, a);
    ok &= a;
    d = 16'h0000;
    for (int i = 0; i < n; i++)
    begin
      byte_in(i == n - 1, b);
      d = {d[7:0], b};
    end
    stop();
  endtask
endmodule
`default_nettype wire

// ### vcr_pkg.sv
// Constants and types shared by the video control register bank files.
package vcr_pkg;

  // Serial chip address; the value is arbitrary.
  localparam logic [6:0] DEV_ADDR = 7'h47;

  localparam logic [7:0] SUB_BLACK_LINE = 8'h12;
  localparam logic [7:0] SUB_PIN_DRIVE = 8'h1F;
  localparam logic [7:0] SUB_SYNC_OUT = 8'h20;
  localparam logic [7:0] SUB_IND_STATUS = 8'h35;
  localparam logic [7:0] SUB_IND_RD_ADDR = 8'h36;
  localparam logic [7:0] SUB_IND_WR_ADDR = 8'h37;
  localparam logic [7:0] SUB_IND_DATA = 8'h38;

  localparam int ADDR_W = 9;
  localparam int DATA_W = 16;
  localparam int MEM_DEPTH = 512;

  localparam int PIN_AVO_BIT = 3;
  localparam int PIN_SYNC_BIT = 4;
  localparam int PIN_LINE_LOCKED_CLOCK_ONE_BIT = 6;
  localparam int PIN_LINE_LOCKED_CLOCK_TWO_BIT = 7;
  localparam int PIN_FIXED_TWENTY_MHZ_CLOCK_BIT = 8;
  localparam int PIN_FIFO_BIT = 9;
  localparam int PIN_CHROMA_BIT = 10;
  localparam int PIN_LUMA_BIT = 11;
  localparam logic [15:0] PIN_MASK = 16'h0FD8;
  localparam logic [15:0] PIN_RESET = 16'h0000;

  localparam int SYNC_LEAD_LSB = 0;
  localparam int SYNC_HS_INV = 2;
  localparam int SYNC_HC_INV = 3;
  localparam int SYNC_AVO_INV = 4;
  localparam int SYNC_VS_INV = 5;
  localparam int SYNC_FIELD_INV = 7;
  localparam logic [7:0] SYNC_MASK = 8'hBF;
  localparam logic [7:0] SYNC_RESET = 8'h00;

  localparam int STAT_WR_REQ = 0;
  localparam int STAT_RD_REQ = 1;
  localparam int STAT_BUSY = 2;

  localparam int BLK_TOP_LSB = 8;
  localparam int BLK_PIC_BIT = 15;
  localparam logic [6:0] BLK_RESTART_COUNT = 7'h7F;

  localparam logic [8:0] ADDR_RESET = 9'h000;
  localparam logic [8:0] ADDR_STEP = 9'h001;
  localparam logic [3:0] BYTE_LAST_BIT = 4'h7;
  localparam logic [3:0] ACK_DRIVE_CNT = 4'h8;
  localparam logic [3:0] ACK_DONE_CNT = 4'h9;
  localparam logic [1:0] LEAD_MAX = 2'h3;

  typedef enum logic [2:0] {
    st_idle,
    st_addr,
    st_sub,
    st_wr,
    st_rd
  } vcr_ser_st_t;

endpackage

// ### vcr_word_ram.sv
// Word memory of the internal processor, reached through the data port.
`timescale 1ns/1ns
`default_nettype none
module vcr_word_ram
(
  input wire logic clk,
  input wire logic rst,
  input wire logic we,
  input wire logic [vcr_pkg::ADDR_W-1:0] waddr,
  input wire logic [vcr_pkg::DATA_W-1:0] wdata,
  input wire logic [vcr_pkg::ADDR_W-1:0] raddr,
  output logic [vcr_pkg::DATA_W-1:0] rdata
);

  typedef struct packed {
    logic [vcr_pkg::DATA_W-1:0] rdata;
  } vcr_ram_state_t;

  // The array itself has no reset, so it can map onto a block memory.
  logic [vcr_pkg::DATA_W-1:0] mem [vcr_pkg::MEM_DEPTH];
  vcr_ram_state_t q;
  vcr_ram_state_t d;

  always_comb
  begin
    d = q;
    d.rdata = mem[raddr];
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      q <= '0;
    else
      q <= d;
  end

  always_ff @(posedge clk)
  begin
    if (we)
      mem[waddr] <= wdata;
  end

  assign rdata = q.rdata;

endmodule
`default_nettype wire
